/* File: pbspr_regs.svh */
// Purpose: Offsets, field positions and reset values of the port B block.
// Assumes: Printed offsets are word indices; byte address is four times.
// Notes: Definitions only.
`ifndef PBSPR_REGS_SVH
`define PBSPR_REGS_SVH
`define PBSPR_IDX_LATCH 16'h000b
`define PBSPR_IDX_PIN_READ 16'h0018
`define PBSPR_IDX_DIR 16'h0f25
`define PBSPR_IDX_ALT 16'h0f3f
`define PBSPR_IDX_DRIVE 16'h0f4c
`define PBSPR_IDX_ROUTE 16'h0fcb
`define PBSPR_IDX_IRQ_STAT 16'h1000
`define PBSPR_IDX_IRQ_MASK 16'h1001
`define PBSPR_ADR(idx) ((idx) << 2)
`define PBSPR_MASK_PORT 8'hf0
`define PBSPR_MASK_ALT 8'h70
`define PBSPR_MASK_ROUTE 8'hd3
`define PBSPR_MASK_IRQ 8'hf1
`define PBSPR_RST_PORT 4'h0
`define PBSPR_RST_ROUTE 8'h00
`define PBSPR_POS_TIMER 6
`define PBSPR_POS_GROUP 4
`define PBSPR_POS_PAIR 0
`define PBSPR_POS_ROUTE_EVT 0
`endif

/* File: pbspr_pkg.sv */
// Purpose: Types shared by the port B block.
// Assumes: Nothing beyond the header.
// Notes: Encodings follow the routing register fields.
package pbspr_pkg;
	// Which two serial units are switched on.
	typedef enum logic [1:0] {
		PAIR_UART_TWI = 2'h0,
		PAIR_UART_SYNC = 2'h1,
		PAIR_SYNC_TWI = 2'h2,
		PAIR_RESERVED = 2'h3
	} pbspr_pair_type;
	// Source of the timer A0 capture input.
	typedef enum logic [1:0] {
		TMR_P72 = 2'h0,
		TMR_P21 = 2'h1,
		TMR_P91 = 2'h2,
		TMR_RESERVED = 2'h3
	} pbspr_timer_type;
endpackage : pbspr_pkg

/* File: pbspr_route_if.sv */
// Purpose: Carries the routing decisions from the router to the port logic.
// Assumes: One router drives, the port top consumes.
// Notes: Pure wiring, no state.
`timescale 1ns/100ps
interface pbspr_route_if;
	logic uart_en; // Asynchronous unit active.
	logic sync_en; // Synchronous unit active.
	logic twi_en; // Two-wire unit active.
	logic [2:0] pb_alt_ok; // Pins 6..4 may carry a unit output.
	logic [2:0] pb_alt_data; // Unit output levels for pins 6..4.
	logic [2:0] p2_alt_en; // Port 2 pins 2..0 handed to a unit.
	logic [2:0] p2_alt_data; // Unit output levels for port 2 pins 2..0.
	logic uart_rx; // Routed asynchronous receive input.
	logic sync_rx; // Routed synchronous data input.
	logic timer_in; // Routed timer A0 capture input.
	logic slot_rx_irq; // Receive or synchronous interrupt slot.
	logic slot_sh_irq; // Two-wire or synchronous interrupt slot.
	modport router (output uart_en, sync_en, twi_en, pb_alt_ok,
		pb_alt_data, p2_alt_en, p2_alt_data, uart_rx, sync_rx, timer_in,
		slot_rx_irq, slot_sh_irq);
	modport port (input uart_en, sync_en, twi_en, pb_alt_ok,
		pb_alt_data, p2_alt_en, p2_alt_data, uart_rx, sync_rx, timer_in,
		slot_rx_irq, slot_sh_irq);
endinterface : pbspr_route_if

/* File: pbspr_pin_cell.sv */
// Purpose: One port B pin: output select, drive type and read-back.
// Assumes: Pin level is synchronous to the clock.
// Notes: Combinational; the top registers the results.
`timescale 1ns/100ps
module pbspr_pin_cell
(
	input wire logic latch_in,
	input wire logic dir_in,
	input wire logic open_drain_in,
	input wire logic alt_sel_in,
	input wire logic alt_data_in,
	input wire logic pin_in,
	output logic out_out,
	output logic oe_out,
	output logic read_out
);
	logic data; // Level that output mode asks for.

	// A unit output replaces the latch only while its route is live.
	always_comb
	begin
		data = alt_sel_in ? alt_data_in : latch_in;
		// Open drain only ever pulls low; a high level floats.
		oe_out = dir_in & (~open_drain_in | ~data);
		out_out = data & ~open_drain_in;
		// Push-pull output reads zero, else the live pin is returned.
		read_out = pin_in & (~dir_in | open_drain_in);
	end
endmodule : pbspr_pin_cell

/* File: pbspr_route.sv */
// Purpose: Picks the active serial pair, pin group, irq slots, timer input.
// Assumes: Software changes routing only while the units are stopped.
// Notes: Combinational; reserved codes switch everything off.
`timescale 1ns/100ps
module pbspr_route
(
	input wire pbspr_pkg::pbspr_pair_type pair_in,
	input wire logic group_in,
	input wire pbspr_pkg::pbspr_timer_type timer_sel_in,
	input wire logic sclk_in,
	input wire logic so_in,
	input wire logic tx_in,
	input wire logic pb5_in,
	input wire logic p21_in,
	input wire logic p72_in,
	input wire logic p91_in,
	input wire logic rx_irq_in,
	input wire logic sync_irq_in,
	input wire logic twi_irq_in,
	pbspr_route_if.router rt
);
	logic data0; // Shared data output of the group.
	logic rx_pin; // Shared receive pin of the chosen group.
	logic sync_pins; // Sync unit owns the shared pin group.

	// Unit pairing, pin group and interrupt slot mapping.
	always_comb
	begin
		rt.uart_en = (pair_in == pbspr_pkg::PAIR_UART_TWI) |
			(pair_in == pbspr_pkg::PAIR_UART_SYNC);
		rt.sync_en = (pair_in == pbspr_pkg::PAIR_UART_SYNC) |
			(pair_in == pbspr_pkg::PAIR_SYNC_TWI);
		rt.twi_en = (pair_in == pbspr_pkg::PAIR_UART_TWI) |
			(pair_in == pbspr_pkg::PAIR_SYNC_TWI);
		// In the sync-plus-two-wire pair the data pin carries sync data.
		data0 = (pair_in == pbspr_pkg::PAIR_SYNC_TWI) ? so_in : tx_in;
		// Beside the UART the sync unit uses other pins, so the group
		// carries sync clock and data only in the sync-plus-two-wire pair.
		sync_pins = (pair_in == pbspr_pkg::PAIR_SYNC_TWI);
		rx_pin = group_in ? pb5_in : p21_in;
		rt.pb_alt_ok = {3{group_in}} & {sync_pins, rt.uart_en,
			rt.uart_en | (pair_in == pbspr_pkg::PAIR_SYNC_TWI)};
		rt.pb_alt_data = {sclk_in, tx_in, data0};
		rt.p2_alt_en = {3{~group_in}} & {sync_pins, 1'b0,
			rt.uart_en | (pair_in == pbspr_pkg::PAIR_SYNC_TWI)};
		rt.p2_alt_data = {sclk_in, 1'b0, data0};
		rt.uart_rx = rt.uart_en & rx_pin;
		rt.sync_rx = sync_pins & rx_pin;
		// The sync unit borrows whichever slot its partner leaves free.
		rt.slot_rx_irq = (pair_in == pbspr_pkg::PAIR_SYNC_TWI) ?
			sync_irq_in : (rt.uart_en & rx_irq_in);
		rt.slot_sh_irq = (pair_in == pbspr_pkg::PAIR_UART_SYNC) ?
			sync_irq_in : (rt.twi_en & twi_irq_in);
		case (timer_sel_in)
			pbspr_pkg::TMR_P72: rt.timer_in = p72_in;
			pbspr_pkg::TMR_P21: rt.timer_in = p21_in;
			pbspr_pkg::TMR_P91: rt.timer_in = p91_in;
			default: rt.timer_in = 1'b0;
		endcase
	end
endmodule : pbspr_route

/* File: pbspr_top.sv */
// Purpose: Port B pins 7..4 with serial routing, behind an APB slave.
// Assumes: Pins and unit signals are synchronous to sys_clk_in.
// Notes: Every output is a flip-flop; clk_en_in low freezes all state.
//
// Contract
// - Output mode drives the latch level.
// - Direction bit one selects output mode.
// - Function bits hand pins to units.
// - Drive bit one selects open drain.
// - Pin read zero for push-pull output.
// - Exactly two serial units active; the reserved pair code leaves none active.
// - Pair field picks the unit pair.
// - Group bit picks port 2 or B.
// - Timer field picks capture input.
// - Routing also remaps serial interrupts.
// - Receive and transmit follow the group.
`include "pbspr_regs.svh"
`timescale 1ns/100ps
module pbspr_top
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [15:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [3:0] pb_pin_in,
	output logic [3:0] pb_pin_out,
	output logic [3:0] pb_pin_oe_out,
	input wire logic [2:0] p2_pin_in,
	input wire logic p72_pin_in,
	input wire logic p91_pin_in,
	input wire logic sync_serial_clock_in,
	input wire logic sync_serial_out_in,
	input wire logic uart_transmit_in,
	input wire logic receive_interrupt_in,
	input wire logic sync_serial_interrupt_in,
	input wire logic two_wire_interrupt_in,
	output logic [2:0] p2_alt_en_out,
	output logic [2:0] p2_alt_data_out,
	output logic uart_receive_out,
	output logic sync_serial_in_out,
	output logic timer_a0_capture_out,
	output logic async_serial_en_out,
	output logic sync_serial_en_out,
	output logic two_wire_en_out,
	output logic receive_slot_irq_out,
	output logic shared_slot_irq_out,
	output logic irq_out
);

	////////////////////////////////////////////////////////////////////////
	// Registers.

	logic [3:0] latch_ff; // Output latch, bits 7..4.
	logic [3:0] dir_ff; // Direction, bits 7..4.
	logic [2:0] alt_ff; // Alternate function, bits 6..4.
	logic [3:0] drive_ff; // Drive type, bits 7..4.
	logic [7:0] route_ff; // Serial routing register.
	logic [7:0] stat_ff; // Sticky event status.
	logic [7:0] mask_ff; // Interrupt mask, same layout.
	logic [3:0] pin_prev_ff; // Pin levels of the previous cycle.
	logic pin_prev_ok_ff; // Previous pin levels are valid.
	logic [31:0] prdata_ff; // Registered read data.
	logic pready_ff; // Registered ready.
	logic pslverr_ff; // Registered error.

	logic [7:0] nxt_stat; // Status after events and clears.
	logic [7:0] rd_data; // Read mux result.
	logic rd_hit; // Address decodes to a register.
	logic setup; // APB setup phase seen this cycle.
	logic wr_done; // APB write completes at this edge.
	logic [7:0] wbyte; // Low byte of write data.
	logic [3:0] cell_out; // Pin cell drive levels.
	logic [3:0] cell_oe; // Pin cell enables.
	logic [3:0] cell_read; // Pin cell read-back.
	logic [3:0] alt_sel; // Per-pin alternate select.
	logic [3:0] alt_data; // Per-pin alternate level.
	logic [3:0] pin_evt; // Input pin change events.
	logic route_evt; // Routing register write changed a value.
	pbspr_pkg::pbspr_pair_type pair; // Decoded pair field.
	pbspr_pkg::pbspr_timer_type tsel; // Decoded timer field.

	pbspr_route_if rt (); // Routing results.

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	// Setup and write strobes derived from the APB handshake.
	always_comb
	begin
		setup = psel_in & ~penable_in;
		wr_done = psel_in & penable_in & pready_ff & pwrite_in;
		wbyte = pwdata_in[7:0];
	end

	// Read mux; the pin-read register returns live levels.
	always_comb
	begin
		rd_hit = 1'b1;
		case (paddr_in)
			`PBSPR_ADR(`PBSPR_IDX_LATCH): rd_data = {latch_ff, 4'h0};
			`PBSPR_ADR(`PBSPR_IDX_PIN_READ):
				rd_data = {cell_read, 4'h0};
			`PBSPR_ADR(`PBSPR_IDX_DIR): rd_data = {dir_ff, 4'h0};
			`PBSPR_ADR(`PBSPR_IDX_ALT):
				rd_data = {1'b0, alt_ff, 4'h0};
			`PBSPR_ADR(`PBSPR_IDX_DRIVE): rd_data = {drive_ff, 4'h0};
			`PBSPR_ADR(`PBSPR_IDX_ROUTE): rd_data = route_ff;
			`PBSPR_ADR(`PBSPR_IDX_IRQ_STAT): rd_data = stat_ff;
			`PBSPR_ADR(`PBSPR_IDX_IRQ_MASK): rd_data = mask_ff;
			default:
			begin
				// Unmapped addresses read zero and flag an error.
				rd_data = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Ready rises after setup so every access has one access cycle.
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end
		else if (clk_en_in)
		begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~rd_hit;
			// Read data is caught in setup and held through the access.
			if (setup)
			begin
				prdata_ff <= {24'h000000, rd_data};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port registers.

	// Software writes to the port control registers.
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			latch_ff <= `PBSPR_RST_PORT;
			dir_ff <= `PBSPR_RST_PORT;
			alt_ff <= 3'h0;
			drive_ff <= `PBSPR_RST_PORT;
		end
		else if (clk_en_in && wr_done)
		begin
			// Only implemented bits are kept.
			case (paddr_in)
				`PBSPR_ADR(`PBSPR_IDX_LATCH):
					latch_ff <= wbyte[7:4];
				`PBSPR_ADR(`PBSPR_IDX_DIR):
					dir_ff <= wbyte[7:4];
				`PBSPR_ADR(`PBSPR_IDX_ALT):
					alt_ff <= wbyte[6:4];
				`PBSPR_ADR(`PBSPR_IDX_DRIVE):
					drive_ff <= wbyte[7:4];
				default:
				begin
					// Other addresses leave the port registers alone.
				end
			endcase
		end
	end

	// Routing register; unimplemented bits are masked off on write.
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			route_ff <= `PBSPR_RST_ROUTE;
		end
		else if (clk_en_in && wr_done &&
			paddr_in == `PBSPR_ADR(`PBSPR_IDX_ROUTE))
		begin
			route_ff <= wbyte & `PBSPR_MASK_ROUTE;
		end
	end

	// Field decode of the routing register.
	always_comb
	begin
		pair = pbspr_pkg::pbspr_pair_type'(route_ff[`PBSPR_POS_PAIR +: 2]);
		tsel = pbspr_pkg::pbspr_timer_type'(route_ff[`PBSPR_POS_TIMER +: 2]);
		// A write that changes routing is an event for software.
		route_evt = wr_done & (paddr_in == `PBSPR_ADR(`PBSPR_IDX_ROUTE)) &
			((wbyte & `PBSPR_MASK_ROUTE) != route_ff);
	end

	////////////////////////////////////////////////////////////////////////
	// Routing and pins.

	// Serial pair, pin group, interrupt slots and timer input.
	pbspr_route u_route
	(
		.pair_in(pair),
		.group_in(route_ff[`PBSPR_POS_GROUP]),
		.timer_sel_in(tsel),
		.sclk_in(sync_serial_clock_in),
		.so_in(sync_serial_out_in),
		.tx_in(uart_transmit_in),
		.pb5_in(pb_pin_in[1]),
		.p21_in(p2_pin_in[1]),
		.p72_in(p72_pin_in),
		.p91_in(p91_pin_in),
		.rx_irq_in(receive_interrupt_in),
		.sync_irq_in(sync_serial_interrupt_in),
		.twi_irq_in(two_wire_interrupt_in),
		.rt(rt.router)
	);

	// Pin 7 has no alternate function; pins 6..4 need function and route.
	always_comb
	begin
		alt_sel = {1'b0, alt_ff & rt.pb_alt_ok};
		alt_data = {1'b0, rt.pb_alt_data};
	end

	// One cell per pin.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_pin
			pbspr_pin_cell u_cell
			(
				.latch_in(latch_ff[gi]),
				.dir_in(dir_ff[gi]),
				.open_drain_in(drive_ff[gi]),
				.alt_sel_in(alt_sel[gi]),
				.alt_data_in(alt_data[gi]),
				.pin_in(pb_pin_in[gi]),
				.out_out(cell_out[gi]),
				.oe_out(cell_oe[gi]),
				.read_out(cell_read[gi])
			);
		end
	endgenerate

	// Pin and unit outputs, registered so every output is a flip-flop.
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pb_pin_out <= 4'h0;
			pb_pin_oe_out <= 4'h0;
			p2_alt_en_out <= 3'h0;
			p2_alt_data_out <= 3'h0;
			uart_receive_out <= 1'b0;
			sync_serial_in_out <= 1'b0;
			timer_a0_capture_out <= 1'b0;
			async_serial_en_out <= 1'b0;
			sync_serial_en_out <= 1'b0;
			two_wire_en_out <= 1'b0;
			receive_slot_irq_out <= 1'b0;
			shared_slot_irq_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			pb_pin_out <= cell_out;
			pb_pin_oe_out <= cell_oe;
			p2_alt_en_out <= rt.p2_alt_en;
			p2_alt_data_out <= rt.p2_alt_data;
			uart_receive_out <= rt.uart_rx;
			sync_serial_in_out <= rt.sync_rx;
			timer_a0_capture_out <= rt.timer_in;
			async_serial_en_out <= rt.uart_en;
			sync_serial_en_out <= rt.sync_en;
			two_wire_en_out <= rt.twi_en;
			receive_slot_irq_out <= rt.slot_rx_irq;
			shared_slot_irq_out <= rt.slot_sh_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Events and interrupt.

	// Change detection on pins that are in input mode.
	// The first enabled edge after reset only primes the history, so a
	// pin that idles high is not taken for an edge.
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pin_prev_ff <= 4'h0;
			pin_prev_ok_ff <= 1'b0;
		end
		else if (clk_en_in)
		begin
			pin_prev_ff <= pb_pin_in;
			pin_prev_ok_ff <= 1'b1;
		end
	end

	// Write-one clears; a new event in the same cycle wins.
	always_comb
	begin
		pin_evt = (pb_pin_in ^ pin_prev_ff) & ~dir_ff & {4{pin_prev_ok_ff}};
		nxt_stat = stat_ff;
		if (wr_done && paddr_in == `PBSPR_ADR(`PBSPR_IDX_IRQ_STAT))
		begin
			nxt_stat = stat_ff & ~(wbyte & `PBSPR_MASK_IRQ);
		end
		nxt_stat[7:4] = nxt_stat[7:4] | pin_evt;
		nxt_stat[`PBSPR_POS_ROUTE_EVT] =
			nxt_stat[`PBSPR_POS_ROUTE_EVT] | route_evt;
	end

	// Status, mask and the level interrupt.
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			stat_ff <= 8'h00;
			mask_ff <= 8'h00;
			irq_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			stat_ff <= nxt_stat;
			if (wr_done && paddr_in == `PBSPR_ADR(`PBSPR_IDX_IRQ_MASK))
			begin
				mask_ff <= wbyte & `PBSPR_MASK_IRQ;
			end
			irq_out <= |(nxt_stat & mask_ff);
		end
	end

	// Bus outputs come straight from their flip-flops.
	always_comb
	begin
		prdata_out = prdata_ff;
		pready_out = pready_ff;
		pslverr_out = pslverr_ff;
	end
endmodule : pbspr_top

/* File: pbspr_board.sv */
// Purpose: Board model of the four port B pins outside the block.
// Assumes: Each pin has a pull-up; the board drives only when told to.
// Notes: Pure wire resolution, no state.
`timescale 1ns/100ps
module pbspr_board
(
	input wire logic [3:0] drive_in,
	input wire logic [3:0] oe_in,
	input wire logic [3:0] ext_level_in,
	input wire logic [3:0] ext_en_in,
	output logic [3:0] level_out
);
	////////////////////////////////////////////////////////////////////////
	// The block wins where it drives; else the board; else the pull-up.
	// A released pin must not keep its last level, so it floats high.
	always_comb
	begin
		level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_level_in)
			| (~oe_in & ~ext_en_in);
	end
endmodule : pbspr_board

/* File: pbspr_assertions.sv */
// Purpose: Port-level properties of the port B routing block.
// Assumes: Registered outputs lag their inputs by one enabled edge.
// Notes: Bound to the top module below.
`timescale 1ns/100ps
module pbspr_assertions
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [3:0] pb_pin_in,
	input wire logic [2:0] p2_pin_in,
	input wire logic p72_pin_in,
	input wire logic p91_pin_in,
	input wire logic receive_interrupt_in,
	input wire logic sync_serial_interrupt_in,
	input wire logic two_wire_interrupt_in,
	input wire logic [2:0] p2_alt_data_out,
	input wire logic uart_receive_out,
	input wire logic sync_serial_in_out,
	input wire logic timer_a0_capture_out,
	input wire logic async_serial_en_out,
	input wire logic sync_serial_en_out,
	input wire logic two_wire_en_out,
	input wire logic receive_slot_irq_out,
	input wire logic shared_slot_irq_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////////////////
	// A setup cycle, then a single answer cycle.
	sequence setup_s;
		psel_in && !penable_in && clk_en_in;
	endsequence
	sequence answer_s;
		pready_out ##1 !pready_out;
	endsequence
	apb_answer_a: assert property (setup_s |=> answer_s)
		else $error("Access phase not answered in one cycle.");
	err_with_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("Error flag without ready.");
	upper_zero_a: assert property (prdata_out[31:8] == 24'h0)
		else $error("Unimplemented read bits not zero.");
	pair_count_a: assert property (
		$countones({async_serial_en_out, sync_serial_en_out,
		two_wire_en_out}) inside {0, 2})
		else $error("Serial unit count is not two.");
	rx_gate_a: assert property (!async_serial_en_out |-> !uart_receive_out)
		else $error("Receive routed to a stopped unit.");
	sync_gate_a: assert property (
		!sync_serial_en_out |-> !sync_serial_in_out)
		else $error("Sync input routed to a stopped unit.");
	rx_source_a: assert property (
		uart_receive_out && $past(clk_en_in)
		|-> $past(pb_pin_in[1]) || $past(p2_pin_in[1]))
		else $error("Receive level from no receive pin.");
	timer_src_a: assert property (
		timer_a0_capture_out && $past(clk_en_in)
		|-> $past(p72_pin_in) || $past(p2_pin_in[1]) || $past(p91_pin_in))
		else $error("Timer input from no source pin.");
	rx_slot_a: assert property (
		receive_slot_irq_out && $past(clk_en_in)
		|-> $past(receive_interrupt_in) || $past(sync_serial_interrupt_in))
		else $error("Receive slot raised without a source.");
	sh_slot_a: assert property (
		shared_slot_irq_out && $past(clk_en_in)
		|-> $past(two_wire_interrupt_in) || $past(sync_serial_interrupt_in))
		else $error("Shared slot raised without a source.");
	p2_input_a: assert property (p2_alt_data_out[1] == 1'b0)
		else $error("Port 2 input pin carries output data.");
endmodule : pbspr_assertions
bind pbspr_top pbspr_assertions u_pbspr_chk (.*);

/* File: port_b_serial_pin_routing_tb_top.sv */
// Purpose: Self-checking bench of the port B routing block over APB.
// Assumes: Registered outputs settle one edge after a write completes.
// Notes: Board pins come from the pull-up board model.
`include "pbspr_regs.svh"
`timescale 1ns/100ps
module port_b_serial_pin_routing_tb_top;
	logic sys_clk_in, rst_n_in, clk_en_in, psel_in, penable_in, pwrite_in;
	logic [15:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, q;
	logic pready_out, pslverr_out, e;
	logic [3:0] pb_pin_in, pb_pin_out, pb_pin_oe_out, ext_level, ext_en;
	logic [2:0] p2_pin_in, p2_alt_en_out, p2_alt_data_out;
	logic p72_pin_in, p91_pin_in, sync_serial_clock_in, sync_serial_out_in;
	logic uart_transmit_in, receive_interrupt_in, sync_serial_interrupt_in;
	logic two_wire_interrupt_in, uart_receive_out, sync_serial_in_out;
	logic timer_a0_capture_out, async_serial_en_out, sync_serial_en_out;
	logic two_wire_en_out, receive_slot_irq_out, shared_slot_irq_out, irq_out;
	int fails = 0; // Mismatches seen.
	int num_checks = 0; // Comparisons made.
	logic [2:0] pair_en [4] = '{3'h5, 3'h6, 3'h3, 3'h0}; // Units per pair.
	logic [1:0] slot_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h0}; // Sync irq slot.
	localparam logic [15:0] adr_latch = `PBSPR_ADR(`PBSPR_IDX_LATCH);
	localparam logic [15:0] adr_pin = `PBSPR_ADR(`PBSPR_IDX_PIN_READ);
	localparam logic [15:0] adr_dir = `PBSPR_ADR(`PBSPR_IDX_DIR);
	localparam logic [15:0] adr_alt = `PBSPR_ADR(`PBSPR_IDX_ALT);
	localparam logic [15:0] adr_drive = `PBSPR_ADR(`PBSPR_IDX_DRIVE);
	localparam logic [15:0] adr_route = `PBSPR_ADR(`PBSPR_IDX_ROUTE);
	localparam logic [15:0] adr_stat = `PBSPR_ADR(`PBSPR_IDX_IRQ_STAT);
	localparam logic [15:0] adr_mask = `PBSPR_ADR(`PBSPR_IDX_IRQ_MASK);
	pbspr_top DUT (.*);
	pbspr_board u_board (.drive_in(pb_pin_out), .oe_in(pb_pin_oe_out),
		.ext_level_in(ext_level), .ext_en_in(ext_en), .level_out(pb_pin_in));
	////////////////////////////////////////////////////////////////////////
	// Free-running 125 MHz clock.
	initial
	begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task final_report;
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// Counts one comparison and reports a mismatch.
	task check_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val
	// One APB transfer; request held until pready is seen high.
	task xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 16);
		q = prdata_out;
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (n >= 16)
		begin
			fails++;
			final_report();
		end
	endtask : xfer
	// Write a register.
	task wr(input logic [15:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr
	// Read a register and compare with the expected word.
	task rd_chk(input logic [15:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		check_val(q, exp);
	endtask : rd_chk
	// Lets a write reach the pins, then samples mid-cycle.
	task settle;
		repeat (2) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask : settle
	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		{rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
		{ext_level, ext_en, p2_pin_in, p72_pin_in, p91_pin_in} = '0;
		{sync_serial_clock_in, sync_serial_out_in, uart_transmit_in} = '0;
		{receive_interrupt_in, two_wire_interrupt_in} = '0;
		sync_serial_interrupt_in = 1'b1;
		clk_en_in = 1'b1;
		repeat (3) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		rd_chk(adr_latch, 32'h0);
		rd_chk(adr_dir, 32'h0);
		rd_chk(adr_alt, 32'h0);
		rd_chk(adr_drive, 32'h0);
		rd_chk(adr_route, 32'h0);
		rd_chk(adr_stat, 32'h0);
		wr(adr_latch, 32'hffff_ffff);
		rd_chk(adr_latch, 32'hf0);
		wr(adr_alt, 32'hff);
		rd_chk(adr_alt, 32'h70);
		wr(adr_pin, 32'hff);
		xfer(16'h0100, 1'b0, 32'h0);
		check_val({q[30:0], e}, 32'h1);
		for (int c = 0; c < 4; c++)
		begin
			wr(adr_route, 32'(c));
			settle();
			check_val({async_serial_en_out, sync_serial_en_out,
				two_wire_en_out}, pair_en[c]);
			check_val({receive_slot_irq_out, shared_slot_irq_out},
				slot_exp[c]);
		end
		wr(adr_route, 32'h0);
		@(posedge sys_clk_in);
		{receive_interrupt_in, two_wire_interrupt_in} <= 2'h3;
		sync_serial_interrupt_in <= 1'b0;
		settle();
		check_val({receive_slot_irq_out, shared_slot_irq_out}, 2'h3);
		for (int c = 0; c < 4; c++)
		begin
			wr(adr_route, 32'(c << 6));
			@(posedge sys_clk_in);
			p72_pin_in <= (c == 0) || (c == 3);
			p2_pin_in <= {1'b0, (c == 1) || (c == 3), 1'b0};
			p91_pin_in <= (c == 2) || (c == 3);
			settle();
			check_val(timer_a0_capture_out, c != 3);
		end
		wr(adr_route, 32'h0);
		wr(adr_dir, 32'hf0);
		wr(adr_latch, 32'ha0);
		settle();
		check_val(pb_pin_oe_out, 4'hf);
		check_val(pb_pin_out, 4'ha);
		rd_chk(adr_pin, 32'h0);
		wr(adr_drive, 32'hf0);
		settle();
		check_val({pb_pin_oe_out, pb_pin_out}, 8'h50);
		rd_chk(adr_pin, 32'ha0);
		@(posedge sys_clk_in);
		ext_level <= 4'h6;
		ext_en <= 4'hf;
		wr(adr_dir, 32'h0);
		settle();
		check_val(pb_pin_oe_out, 4'h0);
		rd_chk(adr_pin, 32'h60);
		@(posedge sys_clk_in);
		ext_en <= 4'h0;
		wr(adr_drive, 32'h0);
		wr(adr_latch, 32'h0);
		wr(adr_dir, 32'h70);
		wr(adr_alt, 32'h70);
		wr(adr_route, 32'h11);
		@(posedge sys_clk_in);
		sync_serial_clock_in <= 1'b1;
		settle();
		check_val(pb_pin_out[2:0], 3'h0);
		@(posedge sys_clk_in);
		sync_serial_clock_in <= 1'b0;
		uart_transmit_in <= 1'b1;
		settle();
		check_val(pb_pin_out[2:0], 3'h3);
		wr(adr_route, 32'h12);
		@(posedge sys_clk_in);
		{sync_serial_clock_in, uart_transmit_in, sync_serial_out_in} <= 3'h5;
		settle();
		check_val(pb_pin_out[2:0], 3'h5);
		wr(adr_route, 32'h02);
		settle();
		check_val(pb_pin_out[2:0], 3'h0);
		check_val(p2_alt_data_out & 3'h5, 3'h5);
		check_val(p2_alt_en_out, 3'h5);
		check_val(sync_serial_in_out, 1'b1);
		wr(adr_alt, 32'h0);
		wr(adr_dir, 32'h0);
		wr(adr_route, 32'h10);
		@(posedge sys_clk_in);
		ext_level <= 4'h2;
		ext_en <= 4'hf;
		p2_pin_in <= 3'h0;
		settle();
		check_val(uart_receive_out, 1'b1);
		wr(adr_route, 32'h0);
		settle();
		check_val(uart_receive_out, 1'b0);
		@(posedge sys_clk_in);
		p2_pin_in <= 3'h2;
		settle();
		check_val(uart_receive_out, 1'b1);
		wr(adr_stat, 32'hff);
		wr(adr_mask, 32'h01);
		wr(adr_route, 32'h01);
		settle();
		check_val(irq_out, 1'b1);
		rd_chk(adr_stat, 32'h01);
		wr(adr_stat, 32'h01);
		settle();
		check_val(irq_out, 1'b0);
		wr(adr_mask, 32'hf0);
		@(posedge sys_clk_in);
		ext_level <= 4'h0;
		settle();
		check_val(irq_out, 1'b1);
		rd_chk(adr_stat, 32'h20);
		wr(adr_mask, 32'h0);
		settle();
		check_val(irq_out, 1'b0);
		// A low clock enable freezes the routed receive output.
		@(posedge sys_clk_in);
		clk_en_in <= 1'b0;
		p2_pin_in <= 3'h0;
		settle();
		check_val(uart_receive_out, 1'b1);
		@(posedge sys_clk_in);
		clk_en_in <= 1'b1;
		settle();
		check_val(uart_receive_out, 1'b0);
		final_report();
	end
endmodule : port_b_serial_pin_routing_tb_top
